// *** rtl/mwd_pkg.sv ***
`default_nettype none
package mwd_pkg;
  // ==========================================================
  // microword field positions (vector index, bit 15 is msb)
  localparam int FUNC_HI      = 15;
  localparam int FUNC_LO      = 12;
  localparam int SUB0_POS     = 11;
  localparam int SUB1_POS     = 10;
  localparam int MOD_A_POS    = 9;
  localparam int MOD_B_POS    = 8;
  localparam int PAR_POS      = 7;
  localparam int UNUSED_HI    = 6;
  localparam int UNUSED_LO    = 5;
  localparam int SUB2_POS     = 4;
  localparam int XREG_HI      = 4;
  localparam int XPOS_HI      = 3;
  // ==========================================================
  // formats presented on fmt_sel
  localparam logic [1:0] FMT_NONE = 2'h0;
  localparam logic [1:0] FMT_REG  = 2'h1;
  localparam logic [1:0] FMT_SKIP = 2'h2;
  localparam logic [1:0] FMT_IMM  = 2'h3;
  // ==========================================================
  // register file groups
  localparam logic [1:0] GRP_BASIC = 2'h0;
  localparam logic [1:0] GRP_ONE   = 2'h1;
  localparam logic [1:0] GRP_TWO   = 2'h2;
  localparam logic [1:0] GRP_THREE = 2'h3;
  // ==========================================================
  // register map and fields
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_HOLD   = 8'h08;
  localparam logic [7:0]  ADDR_DECODE = 8'h0C;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_PAR_BIT = 1;
  localparam int          ST_PAR_BIT   = 0;
  localparam int          ST_RSV_BIT   = 1;
  localparam int          ST_VLD_BIT   = 2;
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam logic        CTRL_PAR_RST = 1'b1;
  localparam logic [15:0] HOLD_RST     = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [15:0] MSB_MASK     = 16'h8000;
  localparam logic [7:0]  MSB_BYTE     = 8'h80;
endpackage : mwd_pkg
`default_nettype wire

// *** rtl/microword_format_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
module microword_format_decoder
  import mwd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] cs_word,
  input  wire logic        cs_valid,
  input  wire logic [1:0]  fmt_sel,
  input  wire logic [15:0] modifier_reg,
  input  wire logic [2:0]  proc_state,
  input  wire logic        bcm_mode,
  input  wire logic [4:0]  bcm_reg_num,
  output logic             word_valid,
  output logic [3:0]       func_code,
  output logic [2:0]       subfunc,
  output logic [4:0]       reg_num,
  output logic [1:0]       rf_group,
  output logic [3:0]       bit_pos,
  output logic [15:0]      au_bit_sel,
  output logic [15:0]      bu_mask,
  output logic             parity_err,
  output logic             reserved_err,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] hold_a;
    logic [15:0] hold_b;
    logic        hold_vld;
    logic        fresh;
    logic        dec_en;
    logic        par_en;
    logic        par_err;
    logic        rsv_err;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ==========================================================
  // field decode of the held word
  logic        mod_a;
  logic        mod_b;
  logic [4:0]  x_reg;
  logic [3:0]  x_pos;
  logic [4:0]  num_mod;
  logic [3:0]  pos_mod;
  logic [7:0]  state_bit;
  logic        par_ok;
  logic        rsv_bad;

  assign mod_a     = st_r.hold_a[MOD_A_POS];
  assign mod_b     = st_r.hold_a[MOD_B_POS];
  assign x_reg     = st_r.hold_a[XREG_HI:0];
  assign x_pos     = st_r.hold_a[XPOS_HI:0];
  assign state_bit = MSB_BYTE >> proc_state;
  assign par_ok    = ^st_r.hold_b;
  assign rsv_bad   = |st_r.hold_b[UNUSED_HI:UNUSED_LO];

  always_comb begin
    num_mod = x_reg;
    if (mod_a && !mod_b) begin
      num_mod = x_reg | {2'h0, modifier_reg[6:4]};
    end else if (!mod_a && mod_b) begin
      num_mod = x_reg | {2'h0, modifier_reg[2:0]};
    end
    pos_mod = x_pos;
    if (mod_a && !mod_b) begin
      pos_mod = x_pos | modifier_reg[7:4];
    end else if (!mod_a && mod_b) begin
      pos_mod = x_pos | modifier_reg[3:0];
    end else if (mod_a && mod_b) begin
      pos_mod = x_pos | modifier_reg[7:4] | modifier_reg[3:0];
    end
  end

  always_comb begin
    func_code  = st_r.hold_a[FUNC_HI:FUNC_LO];
    subfunc    = {st_r.hold_a[SUB0_POS], st_r.hold_a[SUB1_POS], 1'b0};
    reg_num    = 5'h00;
    rf_group   = GRP_BASIC;
    bit_pos    = 4'h0;
    au_bit_sel = 16'h0000;
    bu_mask    = 16'h0000;
    case (fmt_sel)
      FMT_REG: begin
        if (bcm_mode) begin
          reg_num = bcm_reg_num;
        end else begin
          reg_num = num_mod;
          if (mod_a && mod_b) begin
            if (x_reg[4]) begin
              rf_group = GRP_THREE;
            end else if (|x_reg[3:1]) begin
              rf_group = GRP_TWO;
            end else begin
              rf_group = GRP_ONE;
            end
          end
        end
      end
      FMT_SKIP: begin
        subfunc    = {st_r.hold_a[SUB0_POS], st_r.hold_a[SUB1_POS],
                      st_r.hold_a[SUB2_POS]};
        bit_pos    = pos_mod;
        au_bit_sel = MSB_MASK >> pos_mod;
      end
      FMT_IMM: begin
        // bit 4 deliberately unused here
        if (mod_a && mod_b) begin
          bit_pos = {1'b0, proc_state};
          bu_mask = {state_bit, state_bit};
        end else begin
          bit_pos = pos_mod;
          bu_mask = MSB_MASK >> pos_mod;
        end
      end
      default: begin
        reg_num = 5'h00;
      end
    endcase
  end

  // ==========================================================
  // bus write and read decode
  logic        do_write;
  logic        do_read;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_known;
  logic [31:0] rd_val;
  logic        rd_known;

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign do_write      = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  assign wr_ctrl       = do_write && st_r.aw_addr == ADDR_CTRL
                         && st_r.wstrb[0];
  assign wr_status     = do_write && st_r.aw_addr == ADDR_STATUS
                         && st_r.wstrb[0];
  assign wr_known      = st_r.aw_addr == ADDR_CTRL
                         || st_r.aw_addr == ADDR_STATUS
                         || st_r.aw_addr == ADDR_HOLD
                         || st_r.aw_addr == ADDR_DECODE;

  always_comb begin
    rd_val   = 32'h0000_0000;
    rd_known = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL: begin
        rd_val[CTRL_EN_BIT]  = st_r.dec_en;
        rd_val[CTRL_PAR_BIT] = st_r.par_en;
      end
      ADDR_STATUS: begin
        rd_val[ST_PAR_BIT] = st_r.par_err;
        rd_val[ST_RSV_BIT] = st_r.rsv_err;
        rd_val[ST_VLD_BIT] = st_r.hold_vld;
      end
      ADDR_HOLD: begin
        rd_val = {st_r.hold_b, st_r.hold_a};
      end
      ADDR_DECODE: begin
        rd_val = {16'h0000, func_code, bit_pos, 1'b0, rf_group, reg_num};
      end
      default: begin
        rd_known = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt       = st_r;
    st_nxt.fresh = 1'b0;
    if (cs_valid && st_r.dec_en) begin
      st_nxt.hold_a   = cs_word;
      st_nxt.hold_b   = cs_word;
      st_nxt.hold_vld = 1'b1;
      st_nxt.fresh    = 1'b1;
    end
    if (wr_status && st_r.wdata[ST_PAR_BIT]) begin
      st_nxt.par_err = 1'b0;
    end
    if (wr_status && st_r.wdata[ST_RSV_BIT]) begin
      st_nxt.rsv_err = 1'b0;
    end
    if (st_r.fresh && st_r.par_en && !par_ok) begin
      st_nxt.par_err = 1'b1;
    end
    if (st_r.fresh && rsv_bad) begin
      st_nxt.rsv_err = 1'b1;
    end
    if (wr_ctrl) begin
      st_nxt.dec_en = st_r.wdata[CTRL_EN_BIT];
      st_nxt.par_en = st_r.wdata[CTRL_PAR_BIT];
    end
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = wr_known ? RESP_OKAY : RESP_SLVERR;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (do_read) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.rresp  = rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r          <= '0;
      st_r.hold_a   <= HOLD_RST;
      st_r.hold_b   <= HOLD_RST;
      st_r.dec_en   <= CTRL_EN_RST;
      st_r.par_en   <= CTRL_PAR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign word_valid   = st_r.hold_vld;
  assign parity_err   = st_r.par_err;
  assign reserved_err = st_r.rsv_err;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp  = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata  = st_r.rdata;
  assign s_axi_rresp  = st_r.rresp;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_HOLD_DUP: assert property (
    word_valid |-> st_r.hold_a == st_r.hold_b)
    else $error("holding registers differ");

  AST_CAPTURE: assert property (
    cs_valid && st_r.dec_en |=> word_valid && st_r.fresh
      && st_r.hold_a == $past(cs_word))
    else $error("fetched word not captured");

  AST_SUBFUNC: assert property (
    fmt_sel == FMT_SKIP |-> subfunc[0] == st_r.hold_a[SUB2_POS]
      && subfunc[2] == st_r.hold_a[SUB0_POS])
    else $error("skip sub-function wrong");

  AST_PARITY: assert property (
    cs_valid && st_r.dec_en && st_r.par_en && !(^cs_word)
      |=> ##1 parity_err)
    else $error("even parity word not flagged");

  AST_REG_OR: assert property (
    fmt_sel == FMT_REG && !bcm_mode && mod_a && !mod_b
      |-> reg_num == (x_reg | {2'h0, modifier_reg[6:4]}))
    else $error("register number or wrong");

  AST_GRP3: assert property (
    fmt_sel == FMT_REG && !bcm_mode && mod_a && mod_b
      && x_reg[4] |-> rf_group == GRP_THREE)
    else $error("group three not selected");

  AST_BCM: assert property (
    fmt_sel == FMT_REG && bcm_mode |-> reg_num == bcm_reg_num
      && rf_group == GRP_BASIC)
    else $error("boundary mode number wrong");

  AST_POS_CLR: assert property (
    fmt_sel != FMT_REG && fmt_sel != FMT_NONE && !mod_a && !mod_b
      |-> bit_pos == x_pos)
    else $error("unmodified bit position wrong");

  AST_STATE_BIT: assert property (
    fmt_sel == FMT_IMM && mod_a && mod_b
      |-> bu_mask[15 - proc_state] && bu_mask[7 - proc_state]
      && $countones(bu_mask) == 2)
    else $error("state-indexed bit wrong");

  AST_BRESP_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  COV_PARITY: cover property (st_r.fresh && !par_ok ##1 parity_err);
  COV_STATE: cover property (word_valid && fmt_sel == FMT_IMM
    && mod_a && mod_b);
  COV_GRP2: cover property (fmt_sel == FMT_REG && rf_group == GRP_TWO);
  COV_WRITE: cover property (do_write ##1 s_axi_bvalid);

endmodule : microword_format_decoder
`default_nettype wire

// *** bench/cstore_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cstore_model (
  input  wire logic [15:0] raw,
  input  wire logic        fetch,
  input  wire logic        bad_par,
  input  wire logic        bad_rsv,
  output logic      [15:0] cs_word,
  output logic             cs_valid
);
  // ==========
  // word with unused bits clear and odd parity, inverted when idle
  logic [15:0] w;
  always_comb begin
    w        = raw;
    w[6:5]   = bad_rsv ? 2'h3 : 2'h0;
    w[7]     = 1'h0;
    w[7]     = ~(^w) ^ bad_par;
    cs_word  = fetch ? w : ~w;
    cs_valid = fetch;
  end
endmodule : cstore_model
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench
  import mwd_pkg::*;
;
  // ==========
  // signals
  logic        aclk, cs_valid, word_valid, parity_err, reserved_err;
  logic        aresetn = 0, fetch = 0, bad_par = 0, bad_rsv = 0;
  logic        bcm_mode = 0;
  logic [15:0] modifier_reg = 0, raw = 0, prev = 0, cs_word;
  logic [1:0]  fmt_sel = 0, rf_group, rsp;
  logic [2:0]  proc_state = 0, subfunc;
  logic [4:0]  bcm_reg_num = 0, reg_num;
  logic [3:0]  func_code, bit_pos, s_axi_wstrb = 4'hF;
  logic [15:0] au_bit_sel, bu_mask;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rnd, rd, r2;
  logic [49:0] ex;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          num_errors = 0, n_compared = 0, cyc = 0;

  microword_format_decoder i_microword_format_decoder (
    .aclk, .aresetn, .cs_word, .cs_valid, .fmt_sel, .modifier_reg,
    .proc_state, .bcm_mode, .bcm_reg_num, .word_valid, .func_code,
    .subfunc, .reg_num, .rf_group, .bit_pos, .au_bit_sel, .bu_mask,
    .parity_err, .reserved_err, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  cstore_model i_cstore_model (
    .raw, .fetch, .bad_par, .bad_rsv, .cs_word, .cs_valid
  );

  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      $display("mismatch t=%0t timeout", $time);
      results();
    end
  end

  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function automatic logic [49:0] dec_exp(input logic [15:0] w,
    input logic [1:0] f, input logic [15:0] m, input logic [2:0] st,
    input logic bc, input logic [4:0] bn);
    logic a = w[9], b = w[8];
    logic [4:0] x = w[4:0], r = 0;
    logic [1:0] g = GRP_BASIC;
    logic [3:0] p = w[3:0] | (a ? m[7:4] : 4'h0) | (b ? m[3:0] : 4'h0);
    logic [2:0] s = {w[11], w[10], 1'h0};
    logic [15:0] ea = 0, eb = 0;
    if (f == FMT_REG) begin
      r = x;
      if (bc) r = bn;
      else if (a && !b) r[2:0] = x[2:0] | m[6:4];
      else if (!a && b) r[2:0] = x[2:0] | m[2:0];
      else if (a && b) g = x[4] ? GRP_THREE :
        (|x[3:1] ? GRP_TWO : GRP_ONE);
    end else if (f == FMT_SKIP) begin
      s[0] = w[4];
      ea = 16'h8000 >> p;
    end else if (f == FMT_IMM) begin
      if (a && b) begin
        p = {1'h0, st};
        eb = {2{8'h80 >> st}};
      end else eb = 16'h8000 >> p;
    end
    return {w[15:12], s, r, g, p, ea, eb};
  endfunction : dec_exp

  task automatic chk(input logic [31:0] seen, exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw, da = 0, dw = 0;
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      n++;
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      da |= ta;
      dw |= tw;
    end while (!(da && dw));
    n = 0;
    do begin
      #1;
      da = s_axi_bvalid === 1'h1;
      r = s_axi_bresp;
      @(posedge aclk);
      n++;
    end while (!da);
    s_axi_bready <= 0;
    chk(n, 2, "b latency");
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic got = 0;
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      #1;
      got = s_axi_arready === 1'h1;
      @(posedge aclk);
      n++;
    end while (!got);
    s_axi_arvalid <= 0;
    n = 0;
    do begin
      #1;
      got = s_axi_rvalid === 1'h1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      n++;
    end while (!got);
    s_axi_rready <= 0;
    chk(n, 1, "r latency");
  endtask : axr

  task automatic word1(input logic bp, br);
    @(posedge aclk);
    rnd = lfsr(rnd);
    raw <= rnd[15:0];
    bad_par <= bp;
    bad_rsv <= br;
    fetch <= 1;
    @(posedge aclk);
    fetch <= 0;
    bad_par <= 0;
    bad_rsv <= 0;
    repeat (2) @(posedge aclk);
  endtask : word1

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    axr(a, rd, rsp);
    chk(rd, exp, "rdata");
  endtask : rdchk

  // ==========
  // tests
  initial begin
    rnd = 32'h4911EB68;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    #1 chk(word_valid, 0, "wv");
    rdchk(ADDR_CTRL, {CTRL_PAR_RST, CTRL_EN_RST});
    rdchk(ADDR_STATUS, 0);
    rdchk(ADDR_HOLD, {2{HOLD_RST}});
    rdchk(8'h10, 0);
    chk(rsp, RESP_SLVERR, "unmapped rd");
    $display("test reset done");
    for (int i = 0; i <= 400; i++) begin
      @(posedge aclk);
      rnd = lfsr(rnd);
      r2 = lfsr(rnd);
      rnd = r2;
      raw <= i < 7 ? {r2[25:20], 2'h3, r2[7:5], 5'h10 >> i} : rnd[15:0];
      fetch <= 1;
      fmt_sel <= (i > 0 && i < 8) ? FMT_REG : r2[17:16];
      modifier_reg <= r2[31:16];
      proc_state <= r2[20:18];
      bcm_mode <= i > 7 && r2[31:29] == 3'h0;
      bcm_reg_num <= r2[27:23];
      #1;
      if (i > 0) begin
        automatic logic [49:0] e = dec_exp(prev, fmt_sel, modifier_reg,
          proc_state, bcm_mode, bcm_reg_num);
        chk(func_code, e[49:46], "func");
        if (fmt_sel != FMT_NONE) chk(subfunc, e[45:43], "sub");
        chk(reg_num, e[42:38], "reg");
        if (fmt_sel == FMT_REG) chk(rf_group, e[37:36], "grp");
        if (fmt_sel[1]) chk(bit_pos, e[35:32], "pos");
        chk(au_bit_sel, e[31:16], "skip");
        chk(bu_mask, e[15:0], "imm");
      end
      prev = cs_word;
    end
    @(posedge aclk);
    fetch <= 0;
    fmt_sel <= FMT_SKIP;
    rdchk(ADDR_HOLD, {prev, prev});
    ex = dec_exp(prev, FMT_SKIP, modifier_reg, proc_state, 1'b0, 5'h00);
    rdchk(ADDR_DECODE, {16'h0000, ex[49:46], ex[35:32], 8'h00});
    rdchk(ADDR_STATUS, 32'h4);
    $display("test decode done");
    axw(ADDR_CTRL, 32'h2, rsp);
    word1(0, 0);
    rdchk(ADDR_HOLD, {prev, prev});
    axw(ADDR_CTRL, 32'h3, rsp);
    $display("test enable done");
    word1(1, 0);
    #1 chk(parity_err, 1, "perr");
    rdchk(ADDR_STATUS, 32'h5);
    axw(ADDR_STATUS, 32'h1, rsp);
    rdchk(ADDR_STATUS, 32'h4);
    word1(0, 1);
    #1 chk(reserved_err, 1, "rerr");
    chk(parity_err, 0, "perr");
    axw(ADDR_STATUS, 32'h2, rsp);
    axw(ADDR_CTRL, 32'h1, rsp);
    word1(1, 0);
    rdchk(ADDR_STATUS, 32'h4);
    $display("test flags done");
    axw(ADDR_HOLD, 32'h0, rsp);
    chk(rsp, RESP_OKAY, "ro wr");
    axw(8'h10, 32'h0, rsp);
    chk(rsp, RESP_SLVERR, "unmapped wr");
    $display("test bus done");
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    #1 chk(word_valid, 0, "wv rst");
    rdchk(ADDR_CTRL, 32'h3);
    rdchk(ADDR_STATUS, 0);
    rdchk(ADDR_HOLD, 0);
    $display("test reset again done");
    results();
  end
endmodule : testbench
`default_nettype wire
